/* File: sim/arunit_properties.sv */
/*
  Checker for arunit_top: bus handshakes, answer timing, status read-back.
  Assumes it is bound to arunit_top, whose ports share one clock.
*/
`timescale 1ns/1ps
`default_nettype none

module arunit_properties
(
  // Clock and reset
  input wire logic        i_clock,
  input wire logic        i_rst_n,
  // Write channels
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic [7:0]  i_awaddr,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic [1:0]  o_bresp,
  // Read channels and interrupt
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic [7:0]  i_araddr,
  input wire logic        o_rvalid,
  input wire logic        i_rready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0]  o_rresp,
  input wire logic        o_irq
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  // Addresses of accepted requests, kept to judge the later answers.
  logic [7:0] rd_addr;
  logic [7:0] wr_addr;

  always_ff @(posedge i_clock)
  begin
    if (i_arvalid && o_arready)
      rd_addr <= i_araddr;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_awvalid && o_awready)
      wr_addr <= i_awaddr;
  end

  a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read data late");
  a_read_hold: assert property (o_rvalid && !i_rready |=>
    o_rvalid && $stable(o_rdata) && $stable(o_rresp))
    else $error("read answer dropped or changed");
  a_write_hold: assert property (o_bvalid && !i_bready |=>
    o_bvalid && $stable(o_bresp)) else $error("write answer dropped");
  a_read_block: assert property (o_rvalid |-> !o_arready)
    else $error("read address taken while answer pending");
  a_write_block: assert property (o_bvalid |-> !o_awready)
    else $error("write address taken while answer pending");
  a_write_answer: assert property (i_awvalid && o_awready && i_wvalid &&
    o_wready |=> !o_bvalid ##1 o_bvalid) else $error("write answer timing");
  a_status_low: assert property (o_rvalid && rd_addr == 8'h18 |->
    o_rdata[5:0] == 6'h0 && o_rdata[31:8] == 24'h0)
    else $error("status unused bits not zero");
  a_unmapped_read: assert property (o_rvalid && rd_addr > 8'h24 |->
    o_rresp == arunit_pkg::RESP_SLVERR && o_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_status_write: assert property (o_bvalid && wr_addr == 8'h18 |->
    o_bresp == arunit_pkg::RESP_SLVERR) else $error("status write taken");

  cover property (o_rvalid && rd_addr == 8'h18 && o_rdata[7]);
  cover property (o_rvalid && rd_addr == 8'h18 && o_rdata[6]);
  cover property ($rose(o_irq));
endmodule

bind arunit_top arunit_properties chk_u
(
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_awvalid(i_awvalid),
  .o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid),
  .o_wready(o_wready), .o_bvalid(o_bvalid), .i_bready(i_bready),
  .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready),
  .i_araddr(i_araddr), .o_rvalid(o_rvalid), .i_rready(i_rready),
  .o_rdata(o_rdata), .o_rresp(o_rresp), .o_irq(o_irq)
);

`default_nettype wire

/* File: sim/mul_div_unit_tb.sv */
/*
  Self-checking bench for arunit_top: ordered operand writes, results,
  flags and interrupt over AXI4-Lite with random ready delays.
  Assumes every bus request is answered within a few cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module mul_div_unit_tb;
  // ----------
  // Signals
  // ----------
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  int          bad_count, cmp_count;
  int          cyc = 0;

  arunit_top dut_u
  (
    .i_clock(clk), .i_rst_n(rst_n), .i_awvalid(awvalid),
    .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid),
    .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
    .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata),
    .o_rresp(rresp), .o_irq(irq)
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // A hung handshake must still end the run with a verdict.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      stop_test();
    end
  end

  // ----------
  // Tasks
  // ----------
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask

  // Ready is raised at once when br is set, else after a random delay, and then held until the answer.
  task automatic wr(input logic [7:0] a, input logic [7:0] v,
                    input logic [1:0] er, input logic br);
    int n;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    awaddr  <= a;
    wdata   <= {24'($urandom), v};
    wstrb   <= 4'h1 | 4'($urandom);
    bready  <= br;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (!bready) bready <= 1'($urandom);
    end
    while (!(bvalid && bready) && n < 60);
    chk(32'(bvalid && bready), 32'h1);
    chk(32'(bresp), 32'(er));
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er,
                    output logic [31:0] v);
    int n;
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'($urandom);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (!rready) rready <= 1'($urandom);
    end
    while (!(rvalid && rready) && n < 60);
    chk(32'(rvalid && rready), 32'h1);
    v = rdata;
    chk(32'(rresp), 32'(er));
  endtask

  task automatic stat(input logic [7:0] e, input logic [7:0] m);
    logic [31:0] v;
    rd(arunit_pkg::ADDR_STATUS, arunit_pkg::RESP_OKAY, v);
    chk(v & {24'hffffff, m}, {24'h0, e & m});
  endtask

  function automatic logic [48:0] expect_res(int op, logic [31:0] x,
                                             logic [15:0] y);
    logic [31:0] a, q;
    logic [15:0] r;
    a = op == 0 ? x : {16'h0, x[15:0]};
    if (op == 2)
    begin
      q = x[15:0] * y;
      return {q > 32'hffff, 16'h0, q};
    end
    q = y == 16'h0 ? 32'hffffffff : a / y;
    r = y == 16'h0 ? a[15:0] : 16'(a % y);
    return {y == 16'h0, r, q};
  endfunction

  // One operation; ill adds an operand write and an operand read while the unit is busy.
  task automatic run(input int op, input logic [31:0] x,
                     input logic [15:0] y, input logic ill);
    logic [23:0] ws, rs;
    logic [48:0] e;
    logic [31:0] v;
    logic [3:0]  k;
    logic [7:0]  m;
    int          t, n, lim;
    ws = op == 0 ? 24'h543210 : op == 1 ? 24'h5410 : 24'h5140;
    rs = op == 2 ? 24'h3210 : ws;
    n = op == 0 ? 6 : 4;
    lim = op == 0 ? 17 : op == 1 ? 9 : 11;
    e = expect_res(op, x, y);
    m = ill ? 8'hbf : 8'hff;
    for (int i = 0; i < n; i++)
    begin
      k = ws[4*i+:4];
      if (1'($urandom))
        rd(arunit_pkg::ADDR_IRQ_STAT, arunit_pkg::RESP_OKAY, v);
      v = (k < 4 ? x : {16'h0, y}) >> (8 * k[1:0]);
      wr(8'(k * 4), v[7:0], arunit_pkg::RESP_OKAY, i == n - 1);
    end
    t = 0;
    if (ill)
    begin
      wr(arunit_pkg::ADDR_OPERAND_2, 8'h00, arunit_pkg::RESP_OKAY,
         1'b1);
      rd(arunit_pkg::ADDR_OPERAND_0, arunit_pkg::RESP_OKAY, v);
      repeat (20) @(posedge clk);
    end
    else
    begin
      while (!irq && t < 40)
      begin
        @(posedge clk);
        t++;
      end
      chk(32'(t), 32'(lim));
    end
    stat({ill, e[48], 6'h0}, m);
    if (ill)
      stat({1'b0, e[48], 6'h0}, m);
    for (int i = 0; i < n && !ill; i++)
    begin
      k = rs[4*i+:4];
      rd(8'(k * 4), arunit_pkg::RESP_OKAY, v);
      chk(v, 32'(8'(e[47:0] >> (8 * k))));
    end
    wr(arunit_pkg::ADDR_IRQ_EN, 8'h00, arunit_pkg::RESP_OKAY, 1'b0);
    chk(32'(irq), 32'h0);
    wr(arunit_pkg::ADDR_IRQ_EN, 8'h03, arunit_pkg::RESP_OKAY, 1'b0);
    chk(32'(irq), 32'h1);
    rd(arunit_pkg::ADDR_IRQ_STAT, arunit_pkg::RESP_OKAY, v);
    chk(v, {30'h0, ill, 1'b1});
    wr(arunit_pkg::ADDR_IRQ_CLR, 8'h03, arunit_pkg::RESP_OKAY, 1'b0);
    chk(32'(irq), 32'h0);
    $display("done op %0d x %h y %h", op, x, y);
  endtask

  // ----------
  // Sequence
  // ----------
  initial
  begin
    logic [31:0] v;
    logic [19:0] bad;
    {awvalid, wvalid, bready, arvalid, rready, rst_n} = 6'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    bad_count = 0;
    cmp_count = 0;
    v = $urandom(32'hfa559add);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    stat(8'h00, 8'hff);
    rd(8'h30, arunit_pkg::RESP_SLVERR, v);
    chk(v, 32'h0);
    wr(arunit_pkg::ADDR_STATUS, 8'hff, arunit_pkg::RESP_SLVERR, 1'b1);
    wr(arunit_pkg::ADDR_IRQ_EN, 8'h03, arunit_pkg::RESP_OKAY, 1'b0);
    $display("done reset and map");
    bad = 20'h54210;
    for (int i = 0; i < 5; i++)
      wr(8'(bad[4*i+:4] * 4), 8'h5a, arunit_pkg::RESP_OKAY, 1'b0);
    wr(arunit_pkg::ADDR_OPERAND_5, 8'h01, arunit_pkg::RESP_OKAY, 1'b0);
    repeat (20) @(posedge clk);
    chk(32'(irq), 32'h0);
    $display("done stray writes");
    run(0, 32'hffffffff, 16'h0001, 1'b0);
    run(0, 32'h12345678, 16'h0000, 1'b0);
    run(1, 32'h0000ffff, 16'hffff, 1'b0);
    run(2, 32'h0000ffff, 16'hffff, 1'b0);
    run(2, 32'h000000ff, 16'h0101, 1'b0);
    run(1, 32'h00001234, 16'h0007, 1'b1);
    repeat (30)
      run($urandom_range(0, 2), $urandom, 16'($urandom),
          $urandom_range(0, 5) == 0);
    stop_test();
  end
endmodule

`default_nettype wire

/* File: src/arunit_pkg.sv */
/*
  Constants for the memory-mapped unsigned multiply/divide unit: register
  byte addresses, status bit positions, write-order tracker states, cycle
  counts for each operation.
  Assumes a 50 MHz system clock and an AXI4-Lite register bus.
*/
`default_nettype none

package arunit_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_OPERAND_0 = 8'h00;
  localparam logic [7:0] ADDR_OPERAND_1 = 8'h04;
  localparam logic [7:0] ADDR_OPERAND_2 = 8'h08;
  localparam logic [7:0] ADDR_OPERAND_3 = 8'h0c;
  localparam logic [7:0] ADDR_OPERAND_4 = 8'h10;
  localparam logic [7:0] ADDR_OPERAND_5 = 8'h14;
  localparam logic [7:0] ADDR_STATUS    = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h20;
  localparam logic [7:0] ADDR_IRQ_CLR   = 8'h24;
  localparam int         ADDR_W         = 8;

  // ----------------------------------------------------------------------
  // Fields
  // ----------------------------------------------------------------------
  localparam int BIT_ERROR    = 7;
  localparam int BIT_OVERFLOW = 6;
  localparam int IRQ_DONE     = 0;
  localparam int IRQ_ERROR    = 1;
  localparam int IRQ_W        = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Timing, in system clock periods
  // ----------------------------------------------------------------------
  localparam logic [4:0] CYC_LONG_DIV  = 5'h11;
  localparam logic [4:0] CYC_SHORT_DIV = 5'h09;
  localparam logic [4:0] CYC_MUL       = 5'h0b;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h0,
    SEQ_W0   = 3'h1,
    SEQ_W01  = 3'h2,
    SEQ_W012 = 3'h3,
    SEQ_W0123 = 3'h4,
    SEQ_W01234 = 3'h5,
    SEQ_W04  = 3'h6,
    SEQ_W041 = 3'h7
  } arunit_seq_t;

  typedef enum logic [1:0] {
    OP_LONG_DIV  = 2'h0,
    OP_SHORT_DIV = 2'h1,
    OP_MUL       = 2'h2
  } arunit_op_t;

endpackage

`default_nettype wire

/* File: src/arunit_top.sv */
/*
  Unsigned multiply/divide unit behind an AXI4-Lite slave.  Software picks
  the operation by the order of its writes to six operand byte registers.
  Assumes one AXI4-Lite master on the same clock as the unit.
*/
`timescale 1ns/1ps
`default_nettype none

module arunit_top
(
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // AXI4-Lite write address and data
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  // AXI4-Lite write response
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  // AXI4-Lite read
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [7:0]  i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  // Interrupt
  output logic             o_irq
);

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [7:0] w_byte;
  logic       w_lane0;
  logic       wr_fire;
  logic       rd_fire;
  logic       wr_is_op;
  logic       rd_is_op;
  logic       wr_mapped;
  logic       rd_mapped;
  logic [2:0] wr_idx;
  logic [2:0] rd_idx;

  assign o_awready = !aw_held && !o_bvalid;
  assign o_wready  = !w_held && !o_bvalid;
  assign o_arready = !o_rvalid;
  assign wr_fire   = aw_held && w_held && !o_bvalid;
  assign rd_fire   = i_arvalid && o_arready;

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
    end
    else
    begin
      if (i_awvalid && o_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= i_awaddr;
      end
      else if (wr_fire)
        aw_held <= 1'b0;
      if (i_wvalid && o_wready)
      begin
        w_held  <= 1'b1;
        w_byte  <= i_wdata[7:0];
        w_lane0 <= i_wstrb[0];
      end
      else if (wr_fire)
        w_held <= 1'b0;
    end
  end

  // Operand bytes are at word addresses 0..5; decode the index once.
  assign wr_idx    = aw_addr[4:2];
  assign rd_idx    = i_araddr[4:2];
  assign wr_is_op  = (aw_addr <= arunit_pkg::ADDR_OPERAND_5)
                     && (aw_addr[1:0] == 2'h0);
  assign rd_is_op  = (i_araddr <= arunit_pkg::ADDR_OPERAND_5)
                     && (i_araddr[1:0] == 2'h0);
  assign wr_mapped = wr_is_op || (aw_addr == arunit_pkg::ADDR_IRQ_EN)
                     || (aw_addr == arunit_pkg::ADDR_IRQ_CLR);
  assign rd_mapped = rd_is_op || (i_araddr == arunit_pkg::ADDR_STATUS)
                     || (i_araddr == arunit_pkg::ADDR_IRQ_STAT)
                     || (i_araddr == arunit_pkg::ADDR_IRQ_EN);

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      o_bvalid <= 1'b0;
      o_bresp  <= arunit_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      o_bvalid <= 1'b1;
      o_bresp  <= wr_mapped ? arunit_pkg::RESP_OKAY
                            : arunit_pkg::RESP_SLVERR;
    end
    else if (i_bready)
      o_bvalid <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Operand store and computation
  // ----------------------------------------------------------------------
  logic [7:0]             operand [6];
  logic                   busy;
  logic [4:0]             cycles;
  arunit_pkg::arunit_op_t op;
  arunit_pkg::arunit_seq_t seq;
  arunit_pkg::arunit_seq_t next_seq;
  logic                   start;
  logic                   done;
  logic                   long_req;
  logic                   op_write;
  logic                   op_touch;
  logic [31:0]            dividend;
  logic [15:0]            divisor;
  logic [31:0]            quotient;
  logic [15:0]            remainder;
  logic [31:0]            product;

  assign op_write = wr_fire && wr_is_op && w_lane0;
  assign op_touch = (wr_fire && wr_is_op) || (rd_fire && rd_is_op);

  // Order tracker; only operand writes move it.
  always_comb
  begin
    next_seq = seq;
    start    = 1'b0;
    if (op_write && !busy)
    begin
      next_seq = arunit_pkg::SEQ_IDLE;
      unique case (seq)
        arunit_pkg::SEQ_IDLE:
          if (wr_idx == 3'h0) next_seq = arunit_pkg::SEQ_W0;
        arunit_pkg::SEQ_W0:
          if (wr_idx == 3'h1) next_seq = arunit_pkg::SEQ_W01;
          else if (wr_idx == 3'h4) next_seq = arunit_pkg::SEQ_W04;
          else if (wr_idx == 3'h0) next_seq = arunit_pkg::SEQ_W0;
        arunit_pkg::SEQ_W01:
          if (wr_idx == 3'h2) next_seq = arunit_pkg::SEQ_W012;
          else if (wr_idx == 3'h4) next_seq = arunit_pkg::SEQ_W01234;
          else if (wr_idx == 3'h0) next_seq = arunit_pkg::SEQ_W0;
        arunit_pkg::SEQ_W012:
          if (wr_idx == 3'h3) next_seq = arunit_pkg::SEQ_W0123;
          else if (wr_idx == 3'h0) next_seq = arunit_pkg::SEQ_W0;
        arunit_pkg::SEQ_W0123:
          if (wr_idx == 3'h4) next_seq = arunit_pkg::SEQ_W01234;
          else if (wr_idx == 3'h0) next_seq = arunit_pkg::SEQ_W0;
        arunit_pkg::SEQ_W01234:
          if (wr_idx == 3'h5) start = 1'b1;
          else if (wr_idx == 3'h0) next_seq = arunit_pkg::SEQ_W0;
        arunit_pkg::SEQ_W04:
          if (wr_idx == 3'h1) next_seq = arunit_pkg::SEQ_W041;
          else if (wr_idx == 3'h0) next_seq = arunit_pkg::SEQ_W0;
        arunit_pkg::SEQ_W041:
          if (wr_idx == 3'h5) start = 1'b1;
          else if (wr_idx == 3'h0) next_seq = arunit_pkg::SEQ_W0;
      endcase
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      seq <= arunit_pkg::SEQ_IDLE;
    else
      seq <= next_seq;
  end

  // Long division is told apart from short by whether byte 2 was written.
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      busy   <= 1'b0;
      cycles <= 5'h00;
      op     <= arunit_pkg::OP_LONG_DIV;
    end
    else if (start)
    begin
      busy <= 1'b1;
      if (seq == arunit_pkg::SEQ_W041)
      begin
        op     <= arunit_pkg::OP_MUL;
        cycles <= arunit_pkg::CYC_MUL;
      end
      else if (long_req)
      begin
        op     <= arunit_pkg::OP_LONG_DIV;
        cycles <= arunit_pkg::CYC_LONG_DIV;
      end
      else
      begin
        op     <= arunit_pkg::OP_SHORT_DIV;
        cycles <= arunit_pkg::CYC_SHORT_DIV;
      end
    end
    else if (busy)
    begin
      cycles <= cycles - 5'h01;
      if (cycles == 5'h01)
        busy <= 1'b0;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      long_req <= 1'b0;
    else if (op_write && !busy && seq == arunit_pkg::SEQ_W01)
      long_req <= (wr_idx == 3'h2);
  end

  assign done = busy && (cycles == 5'h01);

  // The result is computed combinationally and held back until the count
  // expires; area is traded for a simple, exact cycle count.
  assign dividend  = {(op == arunit_pkg::OP_LONG_DIV) ? operand[3] : 8'h00,
                      (op == arunit_pkg::OP_LONG_DIV) ? operand[2] : 8'h00,
                      operand[1], operand[0]};
  assign divisor   = {operand[5], operand[4]};
  assign quotient  = (divisor == 16'h0000) ? 32'hffffffff
                                           : dividend / {16'h0000, divisor};
  assign remainder = (divisor == 16'h0000) ? dividend[15:0]
                     : 16'(dividend % {16'h0000, divisor});
  assign product   = {16'h0000, operand[1], operand[0]}
                     * {16'h0000, divisor};

  // Writes from software land first; results overwrite at completion.
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      for (int k = 0; k < 6; k++)
        operand[k] <= 8'h00;
    end
    else if (done)
    begin
      if (op == arunit_pkg::OP_MUL)
      begin
        {operand[3], operand[2], operand[1], operand[0]} <= product;
      end
      else
      begin
        operand[0] <= quotient[7:0];
        operand[1] <= quotient[15:8];
        if (op == arunit_pkg::OP_LONG_DIV)
        begin
          operand[2] <= quotient[23:16];
          operand[3] <= quotient[31:24];
        end
        {operand[5], operand[4]} <= remainder;
      end
    end
    else if (op_write)
      operand[wr_idx] <= w_byte;
  end

  // ----------------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------------
  logic error_flag;
  logic overflow_flag;
  logic status_rd;

  assign status_rd = rd_fire && (i_araddr == arunit_pkg::ADDR_STATUS);

  // A touch during the run wins over a clearing read in the same cycle.
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      error_flag <= 1'b0;
    else if (busy && op_touch)
      error_flag <= 1'b1;
    else if (status_rd && !busy)
      error_flag <= 1'b0;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      overflow_flag <= 1'b0;
    else if (done)
      overflow_flag <= (op == arunit_pkg::OP_MUL)
                       ? (product[31:16] != 16'h0000)
                       : (divisor == 16'h0000);
  end

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  logic [1:0] irq_stat;
  logic [1:0] irq_en;
  logic [1:0] irq_evt;
  logic [1:0] irq_clr;

  assign irq_evt = {busy && op_touch, done};
  assign irq_clr = (wr_fire && aw_addr == arunit_pkg::ADDR_IRQ_CLR && w_lane0)
                   ? w_byte[1:0] : 2'h0;

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      irq_stat <= 2'h0;
    else
      irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      irq_en <= 2'h0;
    else if (wr_fire && aw_addr == arunit_pkg::ADDR_IRQ_EN && w_lane0)
      irq_en <= w_byte[1:0];
  end

  assign o_irq = |(irq_stat & irq_en);

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h00000000;
      o_rresp  <= arunit_pkg::RESP_OKAY;
    end
    else if (rd_fire)
    begin
      o_rvalid <= 1'b1;
      o_rresp  <= rd_mapped ? arunit_pkg::RESP_OKAY
                            : arunit_pkg::RESP_SLVERR;
      o_rdata  <= 32'h00000000;
      if (rd_is_op)
        o_rdata[7:0] <= operand[rd_idx];
      else if (i_araddr == arunit_pkg::ADDR_STATUS)
      begin
        o_rdata[arunit_pkg::BIT_ERROR]    <= error_flag;
        o_rdata[arunit_pkg::BIT_OVERFLOW] <= overflow_flag;
      end
      else if (i_araddr == arunit_pkg::ADDR_IRQ_STAT)
        o_rdata[1:0] <= irq_stat;
      else if (i_araddr == arunit_pkg::ADDR_IRQ_EN)
        o_rdata[1:0] <= irq_en;
    end
    else if (i_rready)
      o_rvalid <= 1'b0;
  end

endmodule

`default_nettype wire
